// >>> ipmc_defines.vh
`ifndef IPMC_DEFINES_VH
`define IPMC_DEFINES_VH
// ************************************************************
// Register byte addresses
// ************************************************************
`define IPMC_ADDR_FLAG     8'h00
`define IPMC_ADDR_MASK     8'h04
`define IPMC_ADDR_OSC      8'h08
`define IPMC_ADDR_PORT     8'h0C
`define IPMC_ADDR_CORE     8'h10
`define IPMC_ADDR_STAT     8'h14
// ************************************************************
// Flag and mask bit positions
// ************************************************************
`define IPMC_BIT_T0        0
`define IPMC_BIT_T1        1
`define IPMC_BIT_WDT       2
`define IPMC_BIT_PORT      3
`define IPMC_BIT_EXT       4
`define IPMC_BIT_LVD       5
`define IPMC_NUM_IRQ       6
// ************************************************************
// Oscillator control field positions
// ************************************************************
`define IPMC_OSC_SEL       0
`define IPMC_OSC_STOP      1
`define IPMC_OSC_MODE_LO   2
`define IPMC_OSC_MODE_HI   3
// ************************************************************
// Port control field positions
// ************************************************************
`define IPMC_PORT_WAKE_LO  0
`define IPMC_PORT_WAKE_HI  5
`define IPMC_PORT_EXT_SEL  6
`define IPMC_PORT_EXT_POL  7
// ************************************************************
// Core command bit positions
// ************************************************************
`define IPMC_CMD_TRAP      0
`define IPMC_CMD_RETURN    1
`define IPMC_CMD_ALLOW     2
`define IPMC_CMD_BLOCK     3
`define IPMC_CMD_SLEEP     4
// ************************************************************
// Encodings, vectors and reset values
// ************************************************************
`define IPMC_PMODE_RUN     2'h0
`define IPMC_PMODE_HALT    2'h1
`define IPMC_PMODE_STBY    2'h2
`define IPMC_VEC_TRAP      12'h001
`define IPMC_VEC_IRQ       12'h008
`define IPMC_RST_FLAG      6'h00
`define IPMC_RST_MASK      6'h00
`define IPMC_RST_PORT      8'h00
`define IPMC_HALT_STABLE   16
`define IPMC_DIV_W         5
`endif

// >>> ipmc_clk_div.v
`timescale 1ns/1ns
`default_nettype none
`include "ipmc_defines.vh"
// ************************************************************
// Instruction clock divider, osc/2 or osc/4
// ************************************************************
module ipmc_clk_div
(
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // Control
  input  wire osc_tick,
  input  wire div_by4,
  // Output
  output reg  instruction_clk
);
  reg  [1:0] cnt_ff;
  wire [1:0] nxt_cnt;
  wire       wrap;

  assign wrap    = div_by4 ? (cnt_ff == 2'h3) : (cnt_ff[0] == 1'b1);
  assign nxt_cnt = wrap ? 2'h0 : cnt_ff + 2'h1;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff          <= 2'h0;
      instruction_clk <= 1'b0;
    end
    else
    begin
      instruction_clk <= 1'b0;
      if (osc_tick)
      begin
        cnt_ff          <= nxt_cnt;
        instruction_clk <= wrap;
      end
    end
  end
endmodule
`default_nettype wire

// >>> ipmc_top.v
`timescale 1ns/1ns
`default_nettype none
`include "ipmc_defines.vh"
// How it works
// - Trap jumps to 0x001, clears global enable
// - Return sets global enable, resumes sequence
// - Allow/block instructions set/clear global enable
// - Events set sticky flags until written 0
// - Flags read set only when masked on
// - Pending enabled flag redirects to 0x008
// - Timer0 wrap down sets its flag
// - Timer1 wrap up sets its flag
// - Watchdog flag only in interrupt option
// - Enabled input port pin change sets flag
// - External select suppresses pin0 change detect
// - Chosen pin0 edge sets external flag
// - Low-voltage falling output sets its flag
// - Instruction clock is osc/2 or osc/4
// - Startup option picks Normal or Slow
// - Mode field 10b enters Standby
// - Fast oscillator stops by stop bit or in Halt
// - Any of six interrupts leaves Standby
// - Wake resumes Normal or Slow per select
// - Mode 01b or sleep enters Halt
module ipmc_top
(
  // AHB-Lite slave
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Configuration options
  input  wire        wdt_irq_option,
  input  wire        startup_fast,
  input  wire        inst_div4,
  // Event inputs from peripherals
  input  wire        timer0_wrap,
  input  wire        timer1_wrap,
  input  wire        wdt_timeout,
  input  wire        low_volt_out,
  input  wire [5:0]  port_b_pins,
  input  wire [5:0]  port_b_is_input,
  // Oscillator ticks
  input  wire        internal_fast_rc,
  input  wire        internal_slow_rc,
  // CPU core
  input  wire        instr_boundary,
  input  wire [4:0]  core_cmd,
  output reg         redirect,
  output reg  [11:0] redirect_vec,
  output reg         exec_stall,
  output reg         global_irq_on,
  // Clock and power outputs
  output reg         fast_osc_clk,
  output reg         slow_osc_clk,
  output reg         fast_osc_on,
  output reg         slow_osc_on,
  output reg         instruction_clk,
  output reg         periph_halted,
  output reg  [1:0]  run_state
);
// ************************************************************
// States
// ************************************************************
  localparam ST_NORMAL  = 2'h0;
  localparam ST_SLOW    = 2'h1;
  localparam ST_STANDBY = 2'h2;
  localparam ST_HALT    = 2'h3;
  localparam CNT_W      = 5;

// ************************************************************
// Input synchronisers
// ************************************************************
  wire [9:0] async_in;
  reg  [9:0] sync1_ff;
  reg  [9:0] sync2_ff;
  reg  [9:0] prev_ff;
  assign async_in = {port_b_pins, low_volt_out, internal_slow_rc, internal_fast_rc,
                     wdt_timeout};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_ff <= 10'h000;
      sync2_ff <= 10'h000;
      prev_ff  <= 10'h000;
    end
    else
    begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  wire [5:0] pin_now  = sync2_ff[9:4];
  wire [5:0] pin_prev = prev_ff[9:4];
  wire       lvd_now  = sync2_ff[3];
  wire       lvd_prev = prev_ff[3];
  wire       wdt_rise = sync2_ff[0] & ~prev_ff[0];
  wire       fast_tick = sync2_ff[1] & ~prev_ff[1];
  wire       slow_tick = sync2_ff[2] & ~prev_ff[2];

// ************************************************************
// Registers
// ************************************************************
  reg [5:0] irq_flag_reg_ff;
  reg [5:0] irq_mask_reg_ff;
  reg [3:0] osc_control_reg_ff;
  reg [7:0] port_ctrl_ff;
  reg [1:0] state_ff;
  reg [CNT_W-1:0] halt_cnt_ff;
  reg       t0_prev_ff;
  reg       t1_prev_ff;
  reg       boot_ff;

  wire       fast_osc_select   = osc_control_reg_ff[`IPMC_OSC_SEL];
  wire       fast_osc_stop     = osc_control_reg_ff[`IPMC_OSC_STOP];
  wire [5:0] port_pin_wake_on  = port_ctrl_ff[`IPMC_PORT_WAKE_HI:`IPMC_PORT_WAKE_LO];
  wire       ext_irq_select    = port_ctrl_ff[`IPMC_PORT_EXT_SEL];
  wire       ext_edge_polarity = port_ctrl_ff[`IPMC_PORT_EXT_POL];
  wire       halted = (state_ff == ST_HALT);
  wire       asleep = halted | (state_ff == ST_STANDBY);

// ************************************************************
// Event detection
// ************************************************************
  wire [5:0] chg_ena = port_b_is_input & port_pin_wake_on
                       & {5'h1F, ~ext_irq_select};
  wire [5:0] evt;
  assign evt[`IPMC_BIT_T0]   = timer0_wrap & ~t0_prev_ff & ~halted;
  assign evt[`IPMC_BIT_T1]   = timer1_wrap & ~t1_prev_ff & ~halted;
  assign evt[`IPMC_BIT_WDT]  = wdt_rise & wdt_irq_option;
  assign evt[`IPMC_BIT_PORT] = |((pin_now ^ pin_prev) & chg_ena);
  assign evt[`IPMC_BIT_EXT]  = ext_irq_select & (pin_now[0] != pin_prev[0])
                               & (pin_now[0] == ~ext_edge_polarity);
  assign evt[`IPMC_BIT_LVD]  = lvd_prev & ~lvd_now & ~halted;

// ************************************************************
// Bus slave
// ************************************************************
  reg        dph_wr_ff;
  reg        dph_rd_ff;
  reg  [7:0] dph_addr_ff;
  wire       take = hsel & hready & htrans[1];
  wire       wr_flag = dph_wr_ff & (dph_addr_ff == `IPMC_ADDR_FLAG);
  wire       wr_mask = dph_wr_ff & (dph_addr_ff == `IPMC_ADDR_MASK);
  wire       wr_osc  = dph_wr_ff & (dph_addr_ff == `IPMC_ADDR_OSC);
  wire       wr_port = dph_wr_ff & (dph_addr_ff == `IPMC_ADDR_PORT);
  wire [5:0] shown = irq_flag_reg_ff & irq_mask_reg_ff;
  reg  [31:0] rd_mux;

  always @*
  begin
    case (haddr)
      `IPMC_ADDR_FLAG: rd_mux = {26'h0, shown};
      `IPMC_ADDR_MASK: rd_mux = {26'h0, irq_mask_reg_ff};
      `IPMC_ADDR_OSC:  rd_mux = {28'h0, osc_control_reg_ff};
      `IPMC_ADDR_PORT: rd_mux = {24'h0, port_ctrl_ff};
      `IPMC_ADDR_STAT: rd_mux = {29'h0, global_irq_on, state_ff};
      default:         rd_mux = 32'h0;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_ff   <= 1'b0;
      dph_rd_ff   <= 1'b0;
      dph_addr_ff <= 8'h00;
      hrdata      <= 32'h0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else
    begin
      dph_wr_ff   <= take & hwrite;
      dph_rd_ff   <= take & ~hwrite;
      dph_addr_ff <= {haddr[7:2], 2'h0};
      if (take & ~hwrite)
        hrdata <= rd_mux;
    end
  end

// ************************************************************
// Flags, masks and control
// ************************************************************
  wire mode_write = wr_osc & ~asleep;
  wire go_halt    = (mode_write & (hwdata[3:2] == `IPMC_PMODE_HALT))
                    | (instr_boundary & core_cmd[`IPMC_CMD_SLEEP]);
  wire go_stby    = mode_write & (hwdata[3:2] == `IPMC_PMODE_STBY);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_flag_reg_ff    <= `IPMC_RST_FLAG;
      irq_mask_reg_ff    <= `IPMC_RST_MASK;
      osc_control_reg_ff <= 4'h1;
      port_ctrl_ff       <= `IPMC_RST_PORT;
      t0_prev_ff         <= 1'b0;
      t1_prev_ff         <= 1'b0;
      boot_ff            <= 1'b1;
    end
    else
    begin
      t0_prev_ff <= timer0_wrap;
      t1_prev_ff <= timer1_wrap;
      boot_ff    <= 1'b0;
      // Write of 0 clears, event set wins
      if (wr_flag)
        irq_flag_reg_ff <= (irq_flag_reg_ff & hwdata[5:0]) | evt;
      else
        irq_flag_reg_ff <= irq_flag_reg_ff | evt;
      if (wr_mask)
        irq_mask_reg_ff <= hwdata[5:0];
      if (wr_port)
        port_ctrl_ff <= hwdata[7:0];
      if (boot_ff)
        osc_control_reg_ff[`IPMC_OSC_SEL] <= startup_fast;
      else if (wr_osc)
        osc_control_reg_ff <= {2'h0, hwdata[1:0]};
    end
  end

// ************************************************************
// Operating mode sequencer
// ************************************************************
  wire any_pend = |irq_flag_reg_ff;
  wire wake_halt = |(irq_flag_reg_ff & 6'h1C);
  reg  [1:0] nxt_state;
  wire [1:0] run_mode = fast_osc_select ? ST_NORMAL : ST_SLOW;

  always @*
  begin
    case (state_ff)
      ST_NORMAL, ST_SLOW:
      begin
        if (go_halt)
          nxt_state = ST_HALT;
        else if (go_stby)
          nxt_state = ST_STANDBY;
        else if (wr_osc)
          nxt_state = hwdata[`IPMC_OSC_SEL] ? ST_NORMAL : ST_SLOW;
        else
          nxt_state = run_mode;
      end
      ST_STANDBY:
        nxt_state = any_pend ? run_mode : ST_STANDBY;
      ST_HALT:
        nxt_state = (wake_halt && halt_cnt_ff == `IPMC_HALT_STABLE) ? run_mode : ST_HALT;
      default:
        nxt_state = run_mode;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff    <= ST_NORMAL;
      halt_cnt_ff <= {CNT_W{1'b0}};
    end
    else
    begin
      state_ff <= boot_ff ? (startup_fast ? ST_NORMAL : ST_SLOW) : nxt_state;
      if (!halted || !wake_halt)
        halt_cnt_ff <= {CNT_W{1'b0}};
      else if (slow_tick && halt_cnt_ff != `IPMC_HALT_STABLE)
        halt_cnt_ff <= halt_cnt_ff + 5'h01;
    end
  end

// ************************************************************
// Global enable and vector redirection
// ************************************************************
  wire hw_req = |(irq_flag_reg_ff & irq_mask_reg_ff) & global_irq_on;
  wire step   = instr_boundary & ~asleep;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      global_irq_on <= 1'b0;
      redirect      <= 1'b0;
      redirect_vec  <= 12'h000;
    end
    else
    begin
      redirect <= 1'b0;
      if (step && core_cmd[`IPMC_CMD_TRAP])
      begin
        redirect      <= 1'b1;
        redirect_vec  <= `IPMC_VEC_TRAP;
        global_irq_on <= 1'b0;
      end
      else if (step && hw_req)
      begin
        redirect      <= 1'b1;
        redirect_vec  <= `IPMC_VEC_IRQ;
        global_irq_on <= 1'b0;
      end
      else if (step && (core_cmd[`IPMC_CMD_RETURN] || core_cmd[`IPMC_CMD_ALLOW]))
        global_irq_on <= 1'b1;
      else if (step && core_cmd[`IPMC_CMD_BLOCK])
        global_irq_on <= 1'b0;
    end
  end

// ************************************************************
// Clock selection and power outputs
// ************************************************************
  wire div_clk;
  wire fast_run = ~halted & ~fast_osc_stop;
  wire osc_tick = fast_osc_select ? (fast_tick & fast_run) : (slow_tick & ~halted);

  ipmc_clk_div u_div
  (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .osc_tick        (osc_tick),
    .div_by4         (inst_div4),
    .instruction_clk (div_clk)
  );

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fast_osc_clk    <= 1'b0;
      slow_osc_clk    <= 1'b0;
      fast_osc_on     <= 1'b1;
      slow_osc_on     <= 1'b1;
      instruction_clk <= 1'b0;
      exec_stall      <= 1'b0;
      periph_halted   <= 1'b0;
      run_state       <= 2'h0;
    end
    else
    begin
      fast_osc_clk    <= fast_tick & fast_run;
      slow_osc_clk    <= slow_tick & ~halted;
      fast_osc_on     <= fast_run;
      slow_osc_on     <= ~halted;
      instruction_clk <= div_clk & ~asleep;
      exec_stall      <= (nxt_state == ST_STANDBY) | (nxt_state == ST_HALT);
      periph_halted   <= (nxt_state == ST_HALT);
      run_state       <= nxt_state;
    end
  end
endmodule
`default_nettype wire

// >>> ipmc_props.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Checker
// ********
module ipmc_props
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Core
  input wire logic        instr_boundary,
  input wire logic [4:0]  core_cmd,
  input wire logic        redirect,
  input wire logic [11:0] redirect_vec,
  input wire logic        exec_stall,
  input wire logic        global_irq_on,
  // Power
  input wire logic        fast_osc_on,
  input wire logic        slow_osc_on,
  input wire logic        periph_halted,
  input wire logic [1:0]  run_state
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = instr_boundary && !exec_stall;
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  trap_vec_a: assert property (take && core_cmd[0] |=>
    redirect && redirect_vec == 12'h001 && !global_irq_on)
    else $error("trap redirect wrong");
  reenable_a: assert property (take && (core_cmd[1] || core_cmd[2])
    && !global_irq_on |=> global_irq_on)
    else $error("global enable not set");
  block_clear_a: assert property (take && core_cmd[3] |=> !global_irq_on)
    else $error("global enable not cleared");
  irq_vec_a: assert property (redirect && redirect_vec == 12'h008
    |-> $past(global_irq_on) && !global_irq_on)
    else $error("irq redirect wrong");
  on_boundary_a: assert property (redirect |-> $past(instr_boundary))
    else $error("redirect off boundary");
  halt_off_a: assert property ($rose(run_state == 2'h3) |->
    ##[0:2] (!fast_osc_on && !slow_osc_on && periph_halted))
    else $error("halt leaves clocks on");
  stall_hold_a: assert property (run_state[1] && $past(run_state[1])
    |-> exec_stall)
    else $error("no stall while asleep");
  normal_fast_a: assert property (run_state == 2'h0 && $past(run_state) == 2'h0
    |-> fast_osc_on)
    else $error("normal mode without fast osc");
endmodule
bind ipmc_top ipmc_props u_props
(
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .instr_boundary(instr_boundary), .core_cmd(core_cmd), .redirect(redirect),
  .redirect_vec(redirect_vec), .exec_stall(exec_stall),
  .global_irq_on(global_irq_on), .fast_osc_on(fast_osc_on),
  .slow_osc_on(slow_osc_on), .periph_halted(periph_halted),
  .run_state(run_state)
);
`default_nettype wire

// >>> ipmc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Core model
// ********
module ipmc_core_model
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Design side
  input  wire logic        exec_stall,
  input  wire logic        redirect,
  input  wire logic [11:0] redirect_vec,
  output var  logic        instr_boundary,
  output var  logic [4:0]  core_cmd
);
  logic [1:0]  cnt_ff;
  logic [4:0]  cmd_ff;
  logic        pend_ff;
  logic [7:0]  n_redir;
  logic [11:0] last_vec;
  wire         ends = (cnt_ff == 2'h3) && !exec_stall;
  // One instruction every four cycles
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff <= 2'h0;
      instr_boundary <= 1'b0;
      core_cmd <= 5'h00;
      pend_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 2'h1;
      instr_boundary <= ends;
      core_cmd <= (ends && pend_ff) ? cmd_ff : 5'h00;
      if (ends)
        pend_ff <= 1'b0;
    end
  end
  // Redirect log
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      n_redir <= 8'h00;
    else if (redirect)
    begin
      n_redir <= n_redir + 8'h01;
      last_vec <= redirect_vec;
    end
  end
  // Queue one command for the next boundary
  task post(input logic [4:0] c);
  begin
    do @(posedge hclk); while (cnt_ff == 2'h3);
    cmd_ff <= c;
    pend_ff <= 1'b1;
    @(posedge hclk);
    while (pend_ff) @(posedge hclk);
    repeat (8) @(posedge hclk);
  end
  endtask
endmodule
`default_nettype wire

// >>> ipmc_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipmc_defines.vh"
module ipmc_top_bench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, redirect;
  logic [7:0]  haddr;
  logic [1:0]  htrans, run_state;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        wdt_irq_option, startup_fast, inst_div4, instr_boundary;
  logic        exec_stall, global_irq_on, fast_osc_clk, slow_osc_clk;
  logic        fast_osc_on, slow_osc_on, instruction_clk, periph_halted;
  logic [5:0]  ev, pin_in;
  logic [3:0]  osc_cnt, pb_hi;
  logic [4:0]  core_cmd;
  logic [11:0] redirect_vec;
  int          bad_count, num_checks, fcnt, icnt, scnt, n, f0, i0, d;
  ipmc_top dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .wdt_irq_option(wdt_irq_option), .startup_fast(startup_fast),
    .inst_div4(inst_div4), .timer0_wrap(ev[0]), .timer1_wrap(ev[1]),
    .wdt_timeout(ev[2]), .low_volt_out(!ev[5]),
    .port_b_pins({pb_hi, ev[3], ev[4]}), .port_b_is_input(pin_in),
    .internal_fast_rc(osc_cnt[1]), .internal_slow_rc(osc_cnt[3]),
    .instr_boundary(instr_boundary), .core_cmd(core_cmd),
    .redirect(redirect), .redirect_vec(redirect_vec), .exec_stall(exec_stall),
    .global_irq_on(global_irq_on), .fast_osc_clk(fast_osc_clk),
    .slow_osc_clk(slow_osc_clk), .fast_osc_on(fast_osc_on),
    .slow_osc_on(slow_osc_on), .instruction_clk(instruction_clk),
    .periph_halted(periph_halted), .run_state(run_state)
  );
  ipmc_core_model core
  (
    .hclk(hclk), .hresetn(hresetn), .exec_stall(exec_stall),
    .redirect(redirect), .redirect_vec(redirect_vec),
    .instr_boundary(instr_boundary), .core_cmd(core_cmd)
  );
  // ********
  // Clocks, oscillators, counters
  // ********
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    osc_cnt <= osc_cnt + 4'h1;
    fcnt <= fcnt + fast_osc_clk;
    icnt <= icnt + instruction_clk;
    scnt <= scnt + slow_osc_clk;
  end
  // ********
  // Tasks
  // ********
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
  begin
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
  begin
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
  end
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
  begin
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  end
  endtask
  task fire(input int i);
  begin
    ev[i] <= 1'b1;
    repeat (4) @(posedge hclk);
    ev[i] <= 1'b0;
    repeat (8) @(posedge hclk);
  end
  endtask
  task wt(input logic [1:0] s);
    int k;
  begin
    k = 0;
    while (run_state !== s && k < 3000)
    begin
      @(posedge hclk);
      k++;
    end
    chk("wake state", {30'h0, run_state}, {30'h0, s});
  end
  endtask
  task conclude;
  begin
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    repeat (50000) @(posedge hclk);
    bad_count++;
    conclude;
  end
  // ********
  // Tests
  // ********
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, ev, inst_div4, pb_hi} = '0;
    {osc_cnt, fcnt, icnt, scnt, bad_count, num_checks} = '0;
    {wdt_irq_option, startup_fast, hsize, pin_in} = {2'b11, 3'h2, 6'h3F};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc("status", `IPMC_ADDR_STAT, 32'h0);
    rdc("unmapped", 8'h1C, 32'h0);
    fire(0);
    rdc("masked flag", `IPMC_ADDR_FLAG, 32'h0);
    bus(1'b1, `IPMC_ADDR_MASK, 32'h3F);
    rdc("shown flag", `IPMC_ADDR_FLAG, 32'h1);
    bus(1'b1, `IPMC_ADDR_FLAG, 32'h0);
    wdt_irq_option <= 1'b0;
    fire(2);
    rdc("wdt reset option", `IPMC_ADDR_FLAG, 32'h0);
    wdt_irq_option <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, `IPMC_ADDR_PORT, (i == 4) ? 32'h41 : 32'h02);
      fire(i);
      bus(1'b1, `IPMC_ADDR_FLAG, 32'h3F);
      rdc("event flag", `IPMC_ADDR_FLAG, 32'h1 << i);
      bus(1'b1, `IPMC_ADDR_FLAG, 32'h0);
      rdc("flag cleared", `IPMC_ADDR_FLAG, 32'h0);
    end
    bus(1'b1, `IPMC_ADDR_PORT, 32'hC1);
    ev[4] <= 1'b1;
    repeat (8) @(posedge hclk);
    rdc("ext rise ignored", `IPMC_ADDR_FLAG, 32'h0);
    ev[4] <= 1'b0;
    repeat (8) @(posedge hclk);
    rdc("ext fall", `IPMC_ADDR_FLAG, 32'h10);
    bus(1'b1, `IPMC_ADDR_FLAG, 32'h0);
    bus(1'b1, `IPMC_ADDR_PORT, 32'h3E);
    pin_in <= 6'h1F;
    pb_hi <= 4'h8;
    repeat (8) @(posedge hclk);
    rdc("output pin change", `IPMC_ADDR_FLAG, 32'h0);
    pb_hi <= 4'h4;
    repeat (8) @(posedge hclk);
    rdc("upper pin change", `IPMC_ADDR_FLAG, 32'h8);
    bus(1'b1, `IPMC_ADDR_FLAG, 32'h0);
    bus(1'b1, `IPMC_ADDR_MASK, 32'h01);
    n = core.n_redir;
    fire(0);
    repeat (20) @(posedge hclk);
    chk("held off", core.n_redir, n);
    core.post(5'h04);
    chk("irq count", core.n_redir, n + 1);
    chk("irq vector", core.last_vec, 12'h008);
    chk("irq global", global_irq_on, 1'b0);
    bus(1'b1, `IPMC_ADDR_FLAG, 32'h0);
    core.post(5'h02);
    chk("return global", global_irq_on, 1'b1);
    core.post(5'h01);
    chk("trap vector", core.last_vec, 12'h001);
    chk("trap global", global_irq_on, 1'b0);
    core.post(5'h04);
    chk("allow global", global_irq_on, 1'b1);
    core.post(5'h08);
    chk("block global", global_irq_on, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      inst_div4 <= k[0];
      repeat (20) @(posedge hclk);
      f0 = fcnt;
      i0 = icnt;
      repeat (400) @(posedge hclk);
      d = (fcnt - f0) - (icnt - i0) * (2 << k);
      chk("inst divide", 32'(d > -5 && d < 5), 32'h1);
    end
    bus(1'b1, `IPMC_ADDR_OSC, 32'h0);
    rdc("slow state", `IPMC_ADDR_STAT, 32'h1);
    chk("fast kept", fast_osc_on, 1'b1);
    bus(1'b1, `IPMC_ADDR_OSC, 32'h2);
    repeat (3) @(posedge hclk);
    chk("fast stopped", fast_osc_on, 1'b0);
    bus(1'b1, `IPMC_ADDR_OSC, 32'h0A);
    repeat (3) @(posedge hclk);
    chk("standby", {exec_stall, slow_osc_on, run_state}, 4'hE);
    f0 = scnt;
    repeat (64) @(posedge hclk);
    chk("standby slow clk", 32'(scnt - f0 > 2), 32'h1);
    fire(1);
    wt(2'h1);
    bus(1'b1, `IPMC_ADDR_FLAG, 32'h0);
    core.post(5'h10);
    chk("halt", {fast_osc_on, slow_osc_on, periph_halted, run_state}, 5'h07);
    f0 = scnt;
    fire(2);
    chk("halt slow clk", scnt - f0, 32'h0);
    wt(2'h1);
    bus(1'b1, `IPMC_ADDR_FLAG, 32'h0);
    bus(1'b1, `IPMC_ADDR_OSC, 32'h05);
    repeat (3) @(posedge hclk);
    chk("halt by write", run_state, 2'h3);
    fire(3);
    wt(2'h0);
    hresetn <= 1'b0;
    startup_fast <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("slow start", run_state, 2'h1);
    conclude;
  end
endmodule
`default_nettype wire
